// ==== rtl/cpu_regfile_map.vh ====
// Constants for the working register file, pointer pairs, data-space map and status flags.
`ifndef CPU_REGFILE_MAP_VH
`define CPU_REGFILE_MAP_VH
`define NUM_REGS        32
`define REG_IDX_W       5
`define PTR_X_LO        5'h1A
`define PTR_Y_LO        5'h1C
`define PTR_Z_LO        5'h1E
`define DS_REG_LAST     8'h1F
`define DS_IO_FIRST     8'h20
`define DS_IO_LAST      8'h5F
`define DS_EXT_FIRST    8'h60
`define DS_EXT_LAST     8'hFF
`define IO_SPACE_SIZE   64
`define FLAG_I          7
`define FLAG_T          6
`define FLAG_H          5
`define FLAG_S          4
`define FLAG_V          3
`define FLAG_N          2
`define FLAG_Z          1
`define FLAG_C          0
`define STATUS_FLAGS_REGISTER_RESET      8'h00
`define PMODE_NONE      2'h0
`define PMODE_POSTINC   2'h1
`define PMODE_PREDEC    2'h2
`define PMODE_DISP      2'h3
`endif

// ==== rtl/cpu_regfile_status_flags.v ====
// Working register file, pointer unit, data-space decode and status flag register of the core.
//
// Contract
// - Fetch next instruction while current one executes.
// - Thirty-two byte registers, single-cycle read/write.
// - Two operands read, result written, one cycle.
// - Four byte/word operand and result port modes.
// - Registers occupy lowest 32 data addresses.
// - Top six registers form three pointers.
// - Pointers support displacement, post-increment, pre-decrement.
// - One pointer addresses program flash tables.
// - I/O space at data 0x20-0x5F too.
// - Extended I/O only via data-space loads/stores.
// - Status flags updated after every ALU operation.
// - Status register never saved on interrupts.
// - Bit 7 globally gates all interrupts.
// - Interrupt clears enable; return, set-instruction set it.
// - Bit 6 is bit store/load transfer bit.
// - Bit 5 is low-nibble half carry.
// - Bit 4 equals negative XOR overflow.
// - Bit 3 overflow, bit 2 negative.
// - Bit 1 zero, bit 0 carry.
// - Lowest pending vector is served first.
// - Instructions are one or two 16-bit words.
`timescale 1ns/100ps
`include "cpu_regfile_map.vh"

module cpu_regfile_status_flags #(
  parameter NUM_IRQ = 8
) (
  // Clock and reset.
  input  wire                  clk,
  input  wire                  rst_n,
  // Instruction fetch.
  input  wire [15:0]           fetchWord,
  input  wire                  fetchValid,
  input  wire                  fetchSecondWord,
  output reg  [15:0]           execWord_ff,
  output reg  [15:0]           execExtWord_ff,
  output reg                   execValid_ff,
  // Operand and result ports.
  input  wire [4:0]            rdAddrA,
  input  wire [4:0]            rdAddrB,
  input  wire                  wordOperand,
  output reg  [15:0]           operandA_ff,
  output reg  [7:0]            operandB_ff,
  input  wire                  resWrEn,
  input  wire                  resWide,
  input  wire [4:0]            resAddr,
  input  wire [15:0]           resData,
  // Indirect pointer access.
  input  wire                  ptrEn,
  input  wire [1:0]            ptrSel,
  input  wire [1:0]            ptrMode,
  input  wire [5:0]            ptrDisp,
  input  wire                  ptrFlash,
  output reg  [15:0]           dataAddr_ff,
  output reg  [15:0]           flashAddr_ff,
  // Data-space decode.
  input  wire                  ioInstr,
  input  wire [5:0]            ioAddr,
  input  wire                  dsAccess,
  input  wire                  dsWrite,
  input  wire [7:0]            dsWrData,
  output reg                   ioSel_ff,
  output reg  [5:0]            ioSelAddr_ff,
  output reg                   extSel_ff,
  output reg                   ramSel_ff,
  output reg  [7:0]            dsRdData_ff,
  // Status flags.
  input  wire                  aluUpdate,
  input  wire [7:0]            aluFlagMask,
  input  wire                  aluH,
  input  wire                  aluV,
  input  wire                  aluN,
  input  wire                  aluZ,
  input  wire                  aluC,
  input  wire                  bitStoreInstr,
  input  wire                  bitLoadInstr,
  input  wire [4:0]            bitReg,
  input  wire [2:0]            bitPos,
  input  wire                  setIrqEnableInstr,
  input  wire                  clrIrqEnableInstr,
  input  wire                  returnFromIrqInstr,
  input  wire                  sregWrite,
  input  wire [7:0]            sregWrData,
  output reg  [7:0]            statusFlags_ff,
  // Interrupts.
  input  wire [NUM_IRQ-1:0]    irqPending,
  output reg                   irqTake_ff,
  output reg  [7:0]            irqVector_ff
);

  reg  [1:0]  rstSync_ff;
  wire        rstInt_n = rstSync_ff[1];
  reg  [7:0]  regs_ff [0:`NUM_REGS-1];
  reg  [7:0]  nxt_status_flags_register;
  reg  [15:0] ptrVal;
  reg  [15:0] ptrNew;
  reg  [15:0] ptrEff;
  reg  [4:0]  ptrLo;
  reg  [7:0]  irqIdx;
  reg         irqAny;
  reg  [15:0] dsAddr;
  reg         regHit;
  reg         ioHit;
  reg         extHit;
  reg         ramHit;
  integer     k;
  integer     j;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rstSync_ff <= 2'h0;
    else rstSync_ff <= {rstSync_ff[0], 1'b1};
  end

  // Next word is latched while the current one executes.
  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      execWord_ff    <= 16'h0000;
      execExtWord_ff <= 16'h0000;
      execValid_ff   <= 1'b0;
    end else begin
      execValid_ff <= fetchValid & ~fetchSecondWord;
      if (fetchValid && !fetchSecondWord) begin
        execWord_ff <= fetchWord;
      end
      if (fetchValid && fetchSecondWord) begin
        execExtWord_ff <= fetchWord;
      end
    end
  end

  // Pointer selection and addressing variants.
  always @* begin
    case (ptrSel)
      2'h0:    ptrLo = `PTR_X_LO;
      2'h1:    ptrLo = `PTR_Y_LO;
      default: ptrLo = `PTR_Z_LO;
    endcase
    ptrVal = {regs_ff[ptrLo + 5'h01], regs_ff[ptrLo]};
    ptrNew = ptrVal;
    ptrEff = ptrVal;
    case (ptrMode)
      `PMODE_POSTINC: ptrNew = ptrVal + 16'h0001;
      `PMODE_PREDEC: begin
        ptrNew = ptrVal - 16'h0001;
        ptrEff = ptrNew;
      end
      `PMODE_DISP: ptrEff = ptrVal + {10'h000, ptrDisp};
      default: ptrNew = ptrVal;
    endcase
    dsAddr = ptrEn ? ptrEff : {10'h000, ioAddr} + {8'h00, `DS_IO_FIRST};
  end

  // Register array; a result write reaches the operand reads one cycle later.
  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      for (k = 0; k < `NUM_REGS; k = k + 1) regs_ff[k] <= 8'h00;
    end else begin
      if (resWrEn) begin
        regs_ff[resAddr] <= resData[7:0];
        if (resWide) begin
          regs_ff[resAddr | 5'h01] <= resData[15:8];
        end
      end
      if (bitLoadInstr) begin
        regs_ff[bitReg][bitPos] <= statusFlags_ff[`FLAG_T];
      end
      // Displacement and table reads leave the pointer as it was.
      if (ptrEn && !ptrFlash && ptrMode != `PMODE_DISP && ptrMode != `PMODE_NONE) begin
        regs_ff[ptrLo]         <= ptrNew[7:0];
        regs_ff[ptrLo + 5'h01] <= ptrNew[15:8];
      end
      if (dsAccess && dsWrite && regHit) begin
        regs_ff[dsAddr[4:0]] <= dsWrData;
      end
    end
  end

  // Data-space decode of the current access.
  always @* begin
    regHit = (dsAddr <= {8'h00, `DS_REG_LAST});
    ioHit  = (dsAddr >= {8'h00, `DS_IO_FIRST}) && (dsAddr <= {8'h00, `DS_IO_LAST});
    extHit = (dsAddr >= {8'h00, `DS_EXT_FIRST}) && (dsAddr <= {8'h00, `DS_EXT_LAST});
    ramHit = (dsAddr > {8'h00, `DS_EXT_LAST});
  end

  // Operands show the registers as they were before this edge's writes.
  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      operandA_ff <= 16'h0000;
      operandB_ff <= 8'h00;
    end else begin
      if (wordOperand) begin
        operandA_ff <= {regs_ff[rdAddrA | 5'h01], regs_ff[rdAddrA & 5'h1E]};
      end else begin
        operandA_ff <= {8'h00, regs_ff[rdAddrA]};
      end
      operandB_ff <= regs_ff[rdAddrB];
    end
  end

  // Pointer-derived addresses; each holds until the next access of its kind.
  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      dataAddr_ff  <= 16'h0000;
      flashAddr_ff <= 16'h0000;
    end else begin
      if (ptrEn && ptrFlash) begin
        flashAddr_ff <= {regs_ff[`PTR_Z_LO + 5'h01], regs_ff[`PTR_Z_LO]};
      end
      if (ptrEn && !ptrFlash) begin
        dataAddr_ff <= ptrEff;
      end
    end
  end

  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      ioSel_ff     <= 1'b0;
      ioSelAddr_ff <= 6'h00;
      extSel_ff    <= 1'b0;
      ramSel_ff    <= 1'b0;
      dsRdData_ff  <= 8'h00;
    end else begin
      // Short I/O instructions only form 0x20 to 0x5F, so they never select the extended region.
      ioSel_ff     <= (ioInstr | dsAccess) && ioHit;
      ioSelAddr_ff <= dsAddr[5:0] - 6'h20;
      extSel_ff    <= dsAccess && !ioInstr && extHit;
      ramSel_ff    <= dsAccess && !ioInstr && ramHit;
      if (regHit) begin
        dsRdData_ff <= regs_ff[dsAddr[4:0]];
      end else begin
        dsRdData_ff <= 8'h00;
      end
    end
  end

  // Lowest-numbered pending source wins.
  always @* begin
    irqAny = 1'b0;
    irqIdx = 8'h00;
    for (j = NUM_IRQ - 1; j >= 0; j = j - 1) begin
      if (irqPending[j]) begin
        irqAny = 1'b1;
        irqIdx = j[7:0];
      end
    end
  end

  // Status flag next value; instruction-level effects take precedence over a plain register write.
  always @* begin
    nxt_status_flags_register = statusFlags_ff;
    if (sregWrite) nxt_status_flags_register = sregWrData;
    if (aluUpdate) begin
      if (aluFlagMask[`FLAG_H]) begin
        nxt_status_flags_register[`FLAG_H] = aluH;
      end
      if (aluFlagMask[`FLAG_V]) begin
        nxt_status_flags_register[`FLAG_V] = aluV;
      end
      if (aluFlagMask[`FLAG_N]) begin
        nxt_status_flags_register[`FLAG_N] = aluN;
      end
      if (aluFlagMask[`FLAG_Z]) begin
        nxt_status_flags_register[`FLAG_Z] = aluZ;
      end
      if (aluFlagMask[`FLAG_C]) begin
        nxt_status_flags_register[`FLAG_C] = aluC;
      end
    end
    // The sign bit is rebuilt on every update, so a direct write cannot leave it inconsistent.
    nxt_status_flags_register[`FLAG_S] = nxt_status_flags_register[`FLAG_N] ^ nxt_status_flags_register[`FLAG_V];
    if (bitStoreInstr) nxt_status_flags_register[`FLAG_T] = regs_ff[bitReg][bitPos];
    if (setIrqEnableInstr || returnFromIrqInstr) nxt_status_flags_register[`FLAG_I] = 1'b1;
    if (clrIrqEnableInstr) nxt_status_flags_register[`FLAG_I] = 1'b0;
    // Taking an interrupt only drops the enable; the other flags are not stacked.
    if (statusFlags_ff[`FLAG_I] && irqAny && !clrIrqEnableInstr) nxt_status_flags_register[`FLAG_I] = 1'b0;
  end

  always @(posedge clk or negedge rstInt_n) begin
    if (!rstInt_n) begin
      statusFlags_ff <= `STATUS_FLAGS_REGISTER_RESET;
      irqTake_ff     <= 1'b0;
      irqVector_ff   <= 8'h00;
    end else begin
      statusFlags_ff <= nxt_status_flags_register;
      // A clear in the same cycle blocks the interrupt at once.
      irqTake_ff <= statusFlags_ff[`FLAG_I] && irqAny && !clrIrqEnableInstr;
      if (statusFlags_ff[`FLAG_I] && irqAny) begin
        irqVector_ff <= irqIdx;
      end
    end
  end

endmodule // cpu_regfile_status_flags

// ==== test/cpu_regfile_status_flags_sva.sv ====
// Checker for the status flag and interrupt gating relations of the register file block.
`timescale 1ns/100ps
module cpu_regfile_status_flags_sva #(
  parameter NUM_IRQ = 8
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               aluUpdate,
  input wire logic [7:0]         aluFlagMask,
  input wire logic               aluV,
  input wire logic               aluN,
  input wire logic               aluZ,
  input wire logic               aluC,
  input wire logic               setIrqEnableInstr,
  input wire logic               clrIrqEnableInstr,
  input wire logic               returnFromIrqInstr,
  input wire logic [NUM_IRQ-1:0] irqPending,
  input wire logic               irqTake_ff,
  input wire logic [7:0]         statusFlags_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sign_bit: assert property (statusFlags_ff[4] == (statusFlags_ff[3] ^ statusFlags_ff[2]))
    else $error("sign flag differs from N xor V");
  a_irq_gated: assert property ((!statusFlags_ff[7] || clrIrqEnableInstr) |=> !irqTake_ff)
    else $error("interrupt taken while globally disabled");
  a_irq_taken: assert property (statusFlags_ff[7] && !clrIrqEnableInstr && |irqPending && !irqTake_ff |=> irqTake_ff)
    else $error("enabled pending interrupt not taken");
  a_take_clears: assert property (irqTake_ff |-> !statusFlags_ff[7])
    else $error("enable bit still set after interrupt taken");
  a_take_pulse: assert property (irqTake_ff |=> !irqTake_ff)
    else $error("interrupt taken twice in a row");
  a_enable_set: assert property ((setIrqEnableInstr || returnFromIrqInstr) && !clrIrqEnableInstr
    && !(statusFlags_ff[7] && |irqPending) |=> statusFlags_ff[7])
    else $error("enable bit not set by set or return");
  a_enable_clr: assert property (clrIrqEnableInstr |=> !statusFlags_ff[7])
    else $error("enable bit not cleared");
  a_alu_flags: assert property (aluUpdate && aluFlagMask[3:0] == 4'hF |=>
    statusFlags_ff[3:0] == {$past(aluV), $past(aluN), $past(aluZ), $past(aluC)})
    else $error("arithmetic flags not taken from the operation");
endmodule // cpu_regfile_status_flags_sva

bind cpu_regfile_status_flags cpu_regfile_status_flags_sva #(.NUM_IRQ(NUM_IRQ)) i_cpu_regfile_status_flags_sva (.*);

// ==== test/tb_cpu_regfile_status_flags.sv ====
// Self-checking bench for the register file, pointers, data-space decode and status flags.
`timescale 1ns/100ps
`include "cpu_regfile_map.vh"
module tb_cpu_regfile_status_flags;
  logic        clk, rst_n, fetchValid, fetchSecondWord, wordOperand, resWrEn, resWide, ptrEn, ptrFlash;
  logic        ioInstr, dsAccess, dsWrite, aluUpdate, aluH, aluV, aluN, aluZ, aluC, bitStoreInstr;
  logic        bitLoadInstr, setIrqEnableInstr, clrIrqEnableInstr, returnFromIrqInstr, sregWrite;
  logic        execValid_ff, ioSel_ff, extSel_ff, ramSel_ff, irqTake_ff;
  logic [15:0] fetchWord, resData, execWord_ff, execExtWord_ff, operandA_ff, dataAddr_ff, flashAddr_ff;
  logic [7:0]  operandB_ff, dsWrData, dsRdData_ff, aluFlagMask, sregWrData, statusFlags_ff;
  logic [7:0]  irqPending, irqVector_ff;
  logic [5:0]  ptrDisp, ioAddr, ioSelAddr_ff;
  logic [4:0]  rdAddrA, rdAddrB, resAddr, bitReg;
  logic [2:0]  bitPos;
  logic [1:0]  ptrSel, ptrMode;
  int          failCount, totalChecks, cycles;

  cpu_regfile_status_flags i_cpu_regfile_status_flags (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task conclude;
    if (failCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strobes last one cycle, so every step drops them again after the capturing edge.
  task tick;
    @(negedge clk);
    {fetchValid, wordOperand, resWrEn, resWide, ptrEn, ptrFlash, ptrSel, ptrMode, ioInstr, dsAccess, aluUpdate,
     bitStoreInstr, bitLoadInstr, setIrqEnableInstr, clrIrqEnableInstr, returnFromIrqInstr, sregWrite} = '0;
  endtask

  // Cuts a hang short well after the sequence below should have ended.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      failCount++;
      conclude;
    end
  end

  initial begin
    {rst_n, fetchValid, fetchSecondWord, wordOperand, resWrEn, resWide, ptrEn, ptrFlash, ioInstr, dsAccess,
     dsWrite, aluUpdate, aluH, aluV, aluN, aluZ, aluC, bitStoreInstr, bitLoadInstr, setIrqEnableInstr,
     clrIrqEnableInstr, returnFromIrqInstr, sregWrite, fetchWord, resData, dsWrData, aluFlagMask, sregWrData,
     irqPending, ptrDisp, ioAddr, rdAddrA, rdAddrB, resAddr, bitReg, bitPos, ptrSel, ptrMode} = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("flags", statusFlags_ff, 16'h0000);
    fetchWord = 16'h1234; fetchValid = 1'b1; tick; check("exec", execWord_ff, 16'h1234);
    check("valid", {15'h0000, execValid_ff}, 16'h0001);
    fetchWord = 16'hBEEF;
    fetchValid = 1'b1;
    fetchSecondWord = 1'b1;
    tick;
    fetchSecondWord = 1'b0;
    check("ext2", execExtWord_ff, 16'hBEEF);
    check("valid2", {15'h0000, execValid_ff}, 16'h0000);
    resWrEn = 1'b1; resAddr = 5'h03; resData = 16'h00A5; tick;
    resWrEn = 1'b1; resWide = 1'b1; resAddr = `PTR_X_LO; resData = 16'h0003; rdAddrA = 5'h03; tick;
    check("opA", operandA_ff, 16'h00A5);
    resWrEn = 1'b1; resAddr = 5'h03; resData = 16'h005A; rdAddrB = 5'h03; tick;
    check("opB", {8'h00, operandB_ff}, 16'h00A5);
    wordOperand = 1'b1; rdAddrA = 5'h1B; tick; check("opB", {8'h00, operandB_ff}, 16'h005A);
    check("pair", operandA_ff, 16'h0003);
    ptrEn = 1'b1; dsAccess = 1'b1; tick; check("regmap", {8'h00, dsRdData_ff}, 16'h005A);
    ptrEn = 1'b1; ptrMode = `PMODE_POSTINC; tick; check("post", dataAddr_ff, 16'h0003);
    ptrEn = 1'b1; ptrMode = `PMODE_PREDEC; tick; check("pre", dataAddr_ff, 16'h0003);
    ptrEn = 1'b1;
    dsAccess = 1'b1;
    dsWrite = 1'b1;
    dsWrData = 8'h77;
    tick;
    dsWrite = 1'b0;
    tick;
    check("dswr", {8'h00, operandB_ff}, 16'h0077);
    resWrEn = 1'b1; resWide = 1'b1; resAddr = `PTR_Z_LO; resData = 16'h1234; tick;
    ptrEn = 1'b1; ptrFlash = 1'b1; tick; check("flash", flashAddr_ff, 16'h1234);
    ptrEn = 1'b1; ptrSel = 2'h2; ptrMode = `PMODE_DISP; ptrDisp = 6'h05; tick;
    check("disp", dataAddr_ff, 16'h1239);
    resWrEn = 1'b1; resWide = 1'b1; resAddr = `PTR_X_LO; resData = 16'h0060; tick;
    ptrEn = 1'b1; dsAccess = 1'b1; tick; check("ext", {15'h0000, extSel_ff}, 16'h0001);
    ioInstr = 1'b1; ioAddr = 6'h3F; tick; check("io", {ioSel_ff, extSel_ff, ramSel_ff, ioSelAddr_ff}, 16'h013F);
    check("ioaddr", dataAddr_ff, 16'h0060);
    aluUpdate = 1'b1; aluFlagMask = 8'h2F; aluH = 1'b1; aluN = 1'b1; aluC = 1'b1; tick;
    check("alu1", statusFlags_ff, 16'h0035);
    aluUpdate = 1'b1; aluFlagMask = 8'h0F; aluV = 1'b1; aluZ = 1'b1; aluC = 1'b0; tick;
    check("alu2", statusFlags_ff, 16'h002E);
    bitStoreInstr = 1'b1; bitReg = 5'h03; bitPos = 3'h1; tick; check("tset", statusFlags_ff, 16'h006E);
    bitLoadInstr = 1'b1; bitReg = 5'h04; bitPos = 3'h7; rdAddrB = 5'h04; tick; tick;
    check("tload", {8'h00, operandB_ff}, 16'h0080);
    setIrqEnableInstr = 1'b1; tick; check("sei", statusFlags_ff, 16'h00EE);
    irqPending = 8'h14; tick; check("take", {7'h00, irqTake_ff, irqVector_ff}, 16'h0102);
    check("iclr", statusFlags_ff, 16'h006E);
    irqPending = 8'h00; returnFromIrqInstr = 1'b1; tick; check("ret", statusFlags_ff, 16'h00EE);
    clrIrqEnableInstr = 1'b1; irqPending = 8'h01; tick; tick;
    check("gate", {15'h0000, irqTake_ff}, 16'h0000);
    sregWrite = 1'b1; sregWrData = 8'h03; irqPending = 8'h00; tick;
    check("swr", statusFlags_ff, 16'h0003);
    conclude;
  end
endmodule // tb_cpu_regfile_status_flags
